// ### dv/test_usart_master_spi_mode.sv
// Self-checking bench for the master SPI mode against a shift-register slave.
`timescale 1ns/100ps
`default_nettype none
`include "usmspi_consts.vh"
module test_usart_master_spi_mode;
  logic clk = 1'b0, rstn = 1'b0, clock_pin_direction = 1'b0;
  logic transmitter_enable_bit = 1'b1, receiver_enable_bit = 1'b1, clock_polarity = 1'b0, clock_phase = 1'b0;
  logic lsb_first = 1'b0, data_wr = 1'b0, data_rd = 1'b0, rd_d = 1'b0;
  logic [1:0] usart_mode_select = 2'h3;
  logic [`USMSPI_DIV_W-1:0] baud_rate_divisor = 12'h002;
  logic [7:0] data_wdata = 8'h00, prev = 8'h00, b, e, pr;
  logic [7:0] q[6];
  logic [7:0] expq[$];
  wire [7:0] data_rdata, slv_got;
  wire tx_buffer_empty_flag, rx_complete_flag, tx_complete, transfer_clock_pin, transfer_clock_oe, data_out_pin;
  wire data_in_pin;
  int slv_frames, i;
  int errors = 0, compares = 0;
  always #5 clk = ~clk;
  usmspi_top dut_u (.clk, .rstn, .usart_mode_select, .transmitter_enable_bit, .receiver_enable_bit,
    .clock_pin_direction, .baud_rate_divisor, .clock_polarity, .clock_phase, .lsb_first, .data_wr, .data_wdata,
    .data_rd, .data_rdata, .tx_buffer_empty_flag, .rx_complete_flag, .tx_complete, .transfer_clock_pin,
    .transfer_clock_oe, .data_out_pin, .data_in_pin);
  usmspi_slave slv_u (.sck(transfer_clock_pin), .mosi(data_out_pin), .cpol(clock_polarity), .cpha(clock_phase),
    .miso(data_in_pin), .got(slv_got), .frames(slv_frames));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    if (errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic wr_byte(input logic [7:0] d);
    data_wdata = d;
    data_wr = 1'b1;
    tick();
    data_wr = 1'b0;
  endtask
  task automatic rd_byte(input logic [7:0] x);
    chk(8'(rx_complete_flag), 8'h01, "rxc");
    expq.push_back(x);
    data_rd = 1'b1;
    tick();
    data_rd = 1'b0;
    tick();
  endtask
  // The slave counts a frame at its last sample; tx_complete then marks the true end.
  task automatic wait_frames(input int n);
    int k;
    for (k = 0; k < 4000 && !(slv_frames >= n && tx_complete === 1'b1); k++)
      tick();
    if (k == 4000)
    begin
      errors++;
      end_of_test();
    end
    repeat (3) tick();
  endtask
  always @(posedge clk)
  begin
    if (rd_d)
      chk(data_rdata, expq.pop_front(), "data_rdata");
    rd_d <= data_rd;
  end
  initial
  begin
    void'($urandom(32'h387e_2af0));
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b1;
    chk(8'(tx_buffer_empty_flag), 8'h01, "txe_rst");
    chk(8'(rx_complete_flag), 8'h00, "rxc_rst");
    chk(8'(transfer_clock_oe), 8'h00, "oe_off");
    clock_pin_direction = 1'b1;
    for (i = 0; i < 4; i++)
    begin
      {clock_polarity, clock_phase} = 2'(i);
      lsb_first = clock_polarity ^ clock_phase;
      repeat (4) tick();
      b = 8'($urandom);
      e = {<<{b}};
      wr_byte(b);
      wait_frames(i + 1);
      chk(slv_got, lsb_first ? e : b, "wire_byte");
      chk(8'(transfer_clock_pin), 8'(clock_polarity), "clk_idle");
      // The slave returns the previous wire byte MSB first; the master reads it in the current order.
      pr = {<<{prev}};
      rd_byte(lsb_first ? pr : prev);
      prev = lsb_first ? e : b;
    end
    // Six back-to-back writes: the sixth meets a full queue and is lost.
    data_wr = 1'b1;
    for (i = 0; i < 6; i++)
    begin
      q[i] = 8'($urandom);
      data_wdata = q[i];
      chk(8'(tx_buffer_empty_flag), 8'(i < 5), "txe_fill");
      tick();
    end
    data_wr = 1'b0;
    wait_frames(9);
    chk(slv_got, q[4], "wire_last");
    rd_byte(prev);
    rd_byte(q[0]);
    chk(8'(rx_complete_flag), 8'h00, "rxc_empty");
    baud_rate_divisor = 12'h000;
    b = 8'($urandom);
    wr_byte(b);
    wait_frames(10);
    chk(slv_got, b, "wire_fast");
    chk(8'(rx_complete_flag), 8'h01, "rxc_fast");
    receiver_enable_bit = 1'b0;
    tick();
    tick();
    chk(8'(rx_complete_flag), 8'h00, "rxc_flush");
    receiver_enable_bit = 1'b1;
    usart_mode_select = 2'h1;
    wr_byte(8'h3c);
    tick();
    usart_mode_select = 2'h3;
    repeat (40) tick();
    chk(8'(slv_frames), 8'h0a, "no_frame_mode");
    transmitter_enable_bit = 1'b0;
    wr_byte(8'hc3);
    tick();
    transmitter_enable_bit = 1'b1;
    repeat (40) tick();
    chk(8'(slv_frames), 8'h0a, "no_frame_txoff");
    end_of_test();
  end
endmodule // test_usart_master_spi_mode
`default_nettype wire

// ### dv/usmspi_asserts.sv
// Concurrent checks on the ports of the master SPI block, bound into its top module.
`timescale 1ns/100ps
`default_nettype none
`include "usmspi_consts.vh"
module usmspi_asserts (
  input wire clk,
  input wire rstn,
  input wire [1:0] usart_mode_select,
  input wire receiver_enable_bit,
  input wire clock_pin_direction,
  input wire [`USMSPI_DIV_W-1:0] baud_rate_divisor,
  input wire clock_polarity,
  input wire clock_phase,
  input wire data_wr,
  input wire data_rd,
  input wire [7:0] data_rdata,
  input wire tx_buffer_empty_flag,
  input wire rx_complete_flag,
  input wire tx_complete,
  input wire transfer_clock_pin,
  input wire transfer_clock_oe
);
  // Cycles since the clock pin last moved; it saturates so that long idle gaps do not wrap.
  logic [`USMSPI_DIV_W-1:0] hc_r;
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      hc_r <= 12'h000;
    else if ($changed(transfer_clock_pin))
      hc_r <= 12'h000;
    else if (hc_r != 12'hfff)
      hc_r <= hc_r + 12'h001;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  AST_OE: assert property (transfer_clock_oe == (clock_pin_direction && usart_mode_select == 2'h3))
    else $error("clock pin enable wrong");
  // Edges back to idle are timed from the leading edge; a polarity change moves the idle level, so skip it.
  AST_HALF: assert property ($changed(transfer_clock_pin) && $past(transfer_clock_pin) != clock_polarity
    && $past(clock_polarity, 3) == clock_polarity |-> hc_r == baud_rate_divisor)
    else $error("clock half period wrong");
  AST_IDLE: assert property (tx_complete && usart_mode_select == 2'h3
    && $past(clock_polarity, 3) == clock_polarity |-> transfer_clock_pin == clock_polarity)
    else $error("clock idle level wrong");
  AST_RXSET: assert property ($rose(tx_complete) && receiver_enable_bit |-> ##[0:2] rx_complete_flag)
    else $error("no receive flag after frame");
  AST_KEEP: assert property (rx_complete_flag && !data_rd && receiver_enable_bit |=> rx_complete_flag)
    else $error("receive flag lost without read");
  AST_FLUSH: assert property (!receiver_enable_bit |=> !rx_complete_flag)
    else $error("receive flag kept while disabled");
  AST_HOLD: assert property (!data_rd |=> $stable(data_rdata))
    else $error("read data moved without read");
  AST_TXE: assert property (tx_buffer_empty_flag && !data_wr |=> tx_buffer_empty_flag)
    else $error("queue filled without write");
  AST_NOMODE: assert property (usart_mode_select != 2'h3 && $past(usart_mode_select) != 2'h3
    |-> $stable(transfer_clock_pin))
    else $error("clock moved outside spi mode");
  CV_FAST: cover property (baud_rate_divisor == 12'h000 && $changed(transfer_clock_pin));
  CV_MODE3: cover property (clock_polarity && clock_phase && $rose(tx_complete));
  CV_FULL: cover property (data_wr && !tx_buffer_empty_flag);
endmodule // usmspi_asserts
bind usmspi_top usmspi_asserts chk_u (.clk, .rstn, .usart_mode_select, .receiver_enable_bit, .clock_pin_direction,
  .baud_rate_divisor, .clock_polarity, .clock_phase, .data_wr, .data_rd, .data_rdata, .tx_buffer_empty_flag,
  .rx_complete_flag, .tx_complete, .transfer_clock_pin, .transfer_clock_oe);
`default_nettype wire

// ### dv/usmspi_slave.sv
// Behavioural shift-register slave on the far end of the three-wire link.
`timescale 1ns/100ps
`default_nettype none
module usmspi_slave (
  input wire logic sck,
  input wire logic mosi,
  input wire logic cpol,
  input wire logic cpha,
  output var logic miso,
  output var logic [7:0] got,
  output var int frames
);
  logic [7:0] s = 8'h00;
  int n = 0;
  // Out at the top, in at the bottom: each reply is the byte of the previous frame.
  assign miso = s[7];
  // Sample on the leading edge for phase 0, trailing for phase 1.
  always @(sck)
  begin
    if (sck === (cpol ~^ cpha))
    begin
      s = {s[6:0], mosi};
      n = n + 1;
      if (n % 8 == 0)
      begin
        got = s;
        frames = frames + 1;
      end
    end
  end
endmodule // usmspi_slave
`default_nettype wire

// ### rtl/usmspi_consts.vh
// Constants for the master SPI operating mode of the serial unit.
`ifndef USMSPI_CONSTS_VH
`define USMSPI_CONSTS_VH
`define USMSPI_MODE_SPI 2'h3
`define USMSPI_DIV_W 12
`define USMSPI_DIV_RST 12'h000
`define USMSPI_BYTE_W 8
`define USMSPI_RXBUF_DEPTH 2
`define USMSPI_TXFIFO_DEPTH 4
`define USMSPI_BITS 4'h8
`define USMSPI_DATA_RST 8'h00
`endif

// ### rtl/usmspi_fifo.v
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps
`default_nettype none
module usmspi_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk,
  input wire rstn,
  input wire flush,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;
  assign in_ready = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem[rp_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always @(posedge clk)
  begin
    if (push)
    begin
      mem[wp_r] <= in_data;
    end
  end
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end
    else if (flush)
    begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
      end
      if (pop)
      begin
        rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // usmspi_fifo
`default_nettype wire

// ### rtl/usmspi_top.v
// Master SPI operating mode of the serial unit: transmit queue, shifter and receive buffer.
// Functional notes
// - Mode select both ones enables master SPI.
// - Parity, recovery, separate control replaced by shifter.
// - Pins and flags unchanged from serial mode.
// - Internal clock only; always master.
// - Clock rate from divisor, synchronous-master equation.
// - Fastest transfer clock is half system clock.
// - All four polarity/phase modes supported.
// - Bit order selectable, LSB or MSB first.
// - Full duplex; one byte in per out.
// - Writing data starts every transfer.
// - Queued byte loads when shifter ready.
// - Next byte writable while current shifts.
// - Overflow drops newest byte, keeps older.
// - Buffer-empty and receive-complete flags for polling.
// - Receive buffer holds two bytes; third dropped.
// - Receive flag clears when a read empties the buffer.
// - Receiver disable flushes buffer, clears flag.
`timescale 1ns/100ps
`default_nettype none
`include "usmspi_consts.vh"
module usmspi_top (
  input wire clk,
  input wire rstn,
  input wire [1:0] usart_mode_select,
  input wire transmitter_enable_bit,
  input wire receiver_enable_bit,
  input wire clock_pin_direction,
  input wire [`USMSPI_DIV_W-1:0] baud_rate_divisor,
  input wire clock_polarity,
  input wire clock_phase,
  input wire lsb_first,
  input wire data_wr,
  input wire [7:0] data_wdata,
  input wire data_rd,
  output reg [7:0] data_rdata,
  output wire tx_buffer_empty_flag,
  output wire rx_complete_flag,
  output wire tx_complete,
  output reg transfer_clock_pin,
  output wire transfer_clock_oe,
  output reg data_out_pin,
  input wire data_in_pin
);
  localparam ST_IDLE = 2'd0;
  localparam ST_LEAD = 2'd1;
  localparam ST_TRAIL = 2'd2;
  wire spi_on;
  wire fifo_ready;
  wire q_valid;
  wire [7:0] q_data;
  wire q_take;
  reg [1:0] st_r;
  reg [`USMSPI_DIV_W-1:0] bcnt_r;
  reg [3:0] nbit_r;
  reg [7:0] tx_sh_r;
  reg [7:0] rx_sh_r;
  reg [7:0] rxb0_r;
  reg [7:0] rxb1_r;
  reg [1:0] rxn_r;
  reg din_s1_r;
  reg din_s2_r;
  reg txc_r;
  wire tick;
  wire byte_done;
  wire [7:0] rx_full;
  function [7:0] bitrev;
    input [7:0] v;
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1)
      begin
        bitrev[k] = v[7-k];
      end
    end
  endfunction
  // Phase 1 takes its last bit in the closing cycle, so that bit comes straight from the synchroniser.
  function [7:0] rx_pick;
    input phase;
    input lsb;
    input [7:0] sh;
    input [7:0] full;
    begin
      if (phase)
      begin
        rx_pick = full;
      end
      else
      begin
        rx_pick = lsb ? bitrev(sh) : sh;
      end
    end
  endfunction
  function last_bit;
    input [3:0] n;
    begin
      last_bit = (n == `USMSPI_BITS - 4'h1);
    end
  endfunction
  assign spi_on = (usart_mode_select == `USMSPI_MODE_SPI);
  // The clock pin enable comes from the direction bit in SPI mode; transfer_clock_pin still toggles with it low.
  assign transfer_clock_oe = spi_on & clock_pin_direction;
  usmspi_fifo #(
    .WIDTH(8),
    .DEPTH(`USMSPI_TXFIFO_DEPTH),
    .AW(2)
  ) u_txq (
    .clk(clk),
    .rstn(rstn),
    .flush(~transmitter_enable_bit),
    .in_valid(data_wr & spi_on & transmitter_enable_bit),
    .in_ready(fifo_ready),
    .in_data(data_wdata),
    .out_valid(q_valid),
    .out_ready(q_take),
    .out_data(q_data)
  );
  assign tx_buffer_empty_flag = fifo_ready;
  // Load only when the shifter is idle, so a queued byte never disturbs a frame.
  assign q_take = (st_r == ST_IDLE) & spi_on & transmitter_enable_bit;
  // Divisor semantics follow synchronous master: half period is divisor+1 clocks, so 0 gives clk/2.
  assign tick = (bcnt_r == {`USMSPI_DIV_W{1'b0}});
  assign byte_done = (st_r == ST_TRAIL) & tick & last_bit(nbit_r);
  assign rx_full = lsb_first ? bitrev({rx_sh_r[6:0], din_s2_r}) : {rx_sh_r[6:0], din_s2_r};
  assign rx_complete_flag = (rxn_r != 2'd0);
  assign tx_complete = txc_r;
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      din_s1_r <= 1'b0;
      din_s2_r <= 1'b0;
    end
    else
    begin
      din_s1_r <= data_in_pin;
      din_s2_r <= din_s1_r;
    end
  end
  // Transfer engine; parity and recovery logic do not exist in this mode.
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r <= ST_IDLE;
      bcnt_r <= `USMSPI_DIV_RST;
      nbit_r <= 4'h0;
      tx_sh_r <= `USMSPI_DATA_RST;
      rx_sh_r <= `USMSPI_DATA_RST;
      transfer_clock_pin <= 1'b0;
      data_out_pin <= 1'b1;
      txc_r <= 1'b0;
    end
    else
    begin
      case (st_r)
        ST_IDLE:
        begin
          transfer_clock_pin <= clock_polarity;
          if (q_valid & q_take)
          begin
            tx_sh_r <= lsb_first ? bitrev(q_data) : q_data;
            data_out_pin <= lsb_first ? q_data[0] : q_data[7];
            nbit_r <= 4'h0;
            bcnt_r <= baud_rate_divisor;
            txc_r <= 1'b0;
            st_r <= ST_LEAD;
          end
        end
        ST_LEAD:
        begin
          if (tick)
          begin
            bcnt_r <= baud_rate_divisor;
            transfer_clock_pin <= ~clock_polarity;
            if (!clock_phase)
            begin
              rx_sh_r <= {rx_sh_r[6:0], din_s2_r};
            end
            else
            begin
              data_out_pin <= tx_sh_r[7 - nbit_r[2:0]];
            end
            st_r <= ST_TRAIL;
          end
          else
          begin
            bcnt_r <= bcnt_r - 1'b1;
          end
        end
        ST_TRAIL:
        begin
          if (tick)
          begin
            bcnt_r <= baud_rate_divisor;
            transfer_clock_pin <= clock_polarity;
            if (clock_phase)
            begin
              rx_sh_r <= {rx_sh_r[6:0], din_s2_r};
            end
            else if (!last_bit(nbit_r))
            begin
              data_out_pin <= tx_sh_r[6 - nbit_r[2:0]];
            end
            if (last_bit(nbit_r))
            begin
              txc_r <= 1'b1;
              st_r <= ST_IDLE;
            end
            else
            begin
              nbit_r <= nbit_r + 4'h1;
              st_r <= ST_LEAD;
            end
          end
          else
          begin
            bcnt_r <= bcnt_r - 1'b1;
          end
        end
        default:
        begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end
  // Sampling path delay: input passes two flops, so the slave sees about two clocks less margin.
  // At divisor 0 a slave that changes its output on the opposite edge is therefore read one bit late.
  // Receive buffer of two bytes; a third arriving while full is dropped.
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rxb0_r <= `USMSPI_DATA_RST;
      rxb1_r <= `USMSPI_DATA_RST;
      rxn_r <= 2'd0;
      data_rdata <= `USMSPI_DATA_RST;
    end
    else if (!receiver_enable_bit)
    begin
      rxn_r <= 2'd0;
    end
    else
    begin
      if (data_rd & (rxn_r != 2'd0))
      begin
        data_rdata <= rxb0_r;
        rxb0_r <= rxb1_r;
        if (byte_done & (rxn_r == 2'd1))
        begin
          rxb0_r <= rx_pick(clock_phase, lsb_first, rx_sh_r, rx_full);
        end
        else if (byte_done & (rxn_r == 2'd2))
        begin
          rxb1_r <= rx_pick(clock_phase, lsb_first, rx_sh_r, rx_full);
        end
        else
        begin
          rxn_r <= rxn_r - 2'd1;
        end
      end
      else if (byte_done & (rxn_r != 2'd2))
      begin
        if (rxn_r == 2'd0)
        begin
          rxb0_r <= rx_pick(clock_phase, lsb_first, rx_sh_r, rx_full);
        end
        else
        begin
          rxb1_r <= rx_pick(clock_phase, lsb_first, rx_sh_r, rx_full);
        end
        rxn_r <= rxn_r + 2'd1;
      end
    end
  end
endmodule // usmspi_top
`default_nettype wire
